// file: verilog/ccsc_pkg.sv
// Operation
// - Spread code: 0 off, 1-6 quarter steps, 7 -2%
// - Frequency select bit picks first or second frequency
// - Pair select bit picks first or second state
// - Single output select bit picks its state
// - Dual pins serial unless stored bit selects control
// - Pin function follows stored copy, not volatile bit
// - Control mode disables port unless supply grounded
// - First control pin is control input only
// - Reset loads stored configuration into volatile bytes
// - Serial mode reads second, third inputs as zero
// - Defaults: setting 0 hi-Z, setting 1 active
// - Slave port, 7-bit address, up to 400 kbps
// - Single and block byte reads and writes
// - Block bytes ascending, MSB first, stop anytime
// - Block read returns byte count bytes
// - Each written byte takes effect at once
// - Commit copies all; writes refused while busy
// - Busy flag readable at byte 01 bit 6
// - Command bit 7 single, bits 6:0 offset
// - Slave address upper five bits 11011
// - Low two address bits from byte 01
// - Address byte LSB: 1 read, 0 write
// - Three inputs index eight settings, third MSB
package ccsc_pkg;
	localparam int CFG_BYTES = 80;
	localparam int PLL_COUNT = 4;
	localparam int SETTINGS = 8;
	localparam logic [4:0] ADDR_UPPER = 5'h1b;
	localparam logic [6:0] OFF_ID = 7'h00;
	localparam logic [6:0] OFF_ADDR = 7'h01;
	localparam logic [6:0] OFF_PINCFG = 7'h02;
	localparam logic [6:0] OFF_Y1_SEL = 7'h04;
	localparam logic [6:0] OFF_Y1_STATE = 7'h05;
	localparam logic [6:0] OFF_BYTE_COUNT = 7'h06;
	localparam int PLL_BASE = 16;
	localparam int PLL_STRIDE = 16;
	localparam int PLL_SSC_OFF = 0;
	localparam int PLL_FS_OFF = 3;
	localparam int PLL_PAIR_OFF = 5;
	localparam int PLL_STATE_OFF = 6;
	localparam int BIT_BUSY = 6;
	localparam int BIT_NVM_GO = 7;
	localparam int BIT_PIN_CTRL = 6;
	localparam int BIT_SPREAD_DOWN = 4;
	localparam int SSC_BITS = 3;
	localparam logic [2:0] SSC_CODE_MAX = 3'h7;
	localparam logic [3:0] SSC_MAX_STEPS = 4'h8;
	// Output states
	localparam logic [1:0] OST_POWER_DOWN = 2'h0;
	localparam logic [1:0] OST_HIZ = 2'h1;
	localparam logic [1:0] OST_LOW = 2'h2;
	localparam logic [1:0] OST_ACTIVE = 2'h3;
	localparam logic [7:0] DEF_STATES = {4'h0, OST_ACTIVE, OST_HIZ};
	localparam logic [7:0] DEF_SELECT = 8'h02;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_KHZ = 200000;
	localparam int NVM_WRITE_TIME_NS = 20000;
	localparam int NVM_WRITE_CYCLES = NVM_WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int SCL_KHZ = 400;
	localparam int SCL_QUARTER = CLK_KHZ / (4 * SCL_KHZ);
	// Host register map
	localparam logic [4:0] AXI_CMD = 5'h00;
	localparam logic [4:0] AXI_WDATA = 5'h04;
	localparam logic [4:0] AXI_STATUS = 5'h08;
	localparam logic [4:0] AXI_RDATA = 5'h0c;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_READ = 12;
	localparam int CMD_LEN_LSB = 16;
	localparam int CMD_GO = 31;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [7:0] ccsc_factory_byte(input int i);
		logic [7:0] b;
		b = 8'h00;
		if (i == int'(OFF_Y1_SEL) || (i >= PLL_BASE && i % PLL_STRIDE == PLL_PAIR_OFF))
			b = DEF_SELECT;
		if (i == int'(OFF_Y1_STATE) || (i >= PLL_BASE && i % PLL_STRIDE == PLL_STATE_OFF))
			b = DEF_STATES;
		if (i == int'(OFF_BYTE_COUNT))
			b = 8'(CFG_BYTES);
		return b;
	endfunction : ccsc_factory_byte
endpackage : ccsc_pkg

// file: verilog/ccsc_if.sv
`timescale 1ns/1ps
interface ccsc_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	// Outside drivers pulling a pin low while used as a control input
	logic ext_scl_low;
	logic ext_sda_low;
	logic scl;
	logic sda;
	assign scl = ~((host_scl_oe & ~host_scl_o) | ext_scl_low);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o) | ext_sda_low);
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : ccsc_if

// file: verilog/ccsc_device.sv
`timescale 1ns/1ps
module ccsc_device (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stored image back to factory values at reset
	input wire logic nvm_factory_load,
	// Serial lines
	ccsc_if.device bus,
	// Pins
	input wire logic control_pin_first,
	input wire logic output_supply_grounded,
	// Selected settings
	output logic [ccsc_pkg::PLL_COUNT-1:0] pll_freq_select,
	output logic [ccsc_pkg::PLL_COUNT-1:0][3:0] spread_steps,
	output logic [ccsc_pkg::PLL_COUNT-1:0] spread_down,
	output logic [ccsc_pkg::PLL_COUNT-1:0][1:0] pair_output_state,
	output logic [1:0] single_output_state,
	output logic [2:0] setting_index,
	output logic nvm_write_busy,
	output logic serial_enabled
);
	import ccsc_pkg::*;

	localparam int PIN_CTL = 0;
	localparam int PIN_DATA = 1;
	localparam int PIN_CLK = 2;
	localparam int PIN_SUPPLY = 3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_MACK = 3'h4
	} ccsc_dst_t;

	typedef enum logic [1:0] {
		W_ADDR = 2'h0,
		W_CMD = 2'h1,
		W_DATA = 2'h2
	} ccsc_what_t;

	typedef struct packed {
		logic [CFG_BYTES-1:0][7:0] vol;
		logic [CFG_BYTES-1:0][7:0] nvm;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] filt;
		logic [3:0] prev;
		ccsc_dst_t st;
		ccsc_what_t what;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rw;
		logic single;
		logic mack;
		logic [6:0] ptr;
		logic [7:0] rd_left;
		logic sda_oe;
		logic busy;
		logic [15:0] busy_cnt;
		logic [PLL_COUNT-1:0] fs;
		logic [PLL_COUNT-1:0][3:0] steps;
		logic [PLL_COUNT-1:0] down;
		logic [PLL_COUNT-1:0][1:0] pair;
		logic [1:0] single_st;
		logic [2:0] sel;
		logic serial;
	} ccsc_dev_t;

	ccsc_dev_t r_reg;
	ccsc_dev_t r_next;

	function automatic logic [7:0] rd_byte(input ccsc_dev_t s, input logic [6:0] p);
		logic [7:0] b;
		b = 8'h00;
		if (int'(p) < CFG_BYTES)
			b = s.vol[p];
		if (p == OFF_ADDR)
			b[BIT_BUSY] = s.busy;
		return b;
	endfunction : rd_byte

	logic serial;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] wb;
	logic [23:0] ssc_bits;
	int base;

	always_comb begin
		r_next = r_reg;
		wb = 8'h00;
		ssc_bits = 24'h000000;
		base = 0;
		r_next.sync1 = {output_supply_grounded, bus.scl, bus.sda, control_pin_first};
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		r_next.filt = (r_reg.sync2 & r_reg.sync3)
			| (r_reg.filt & (r_reg.sync2 | r_reg.sync3));
		r_next.prev = r_reg.filt;
		// Function taken from the stored copy and the supply pin only
		serial = ~r_reg.nvm[OFF_PINCFG][BIT_PIN_CTRL] | r_reg.filt[PIN_SUPPLY];
		r_next.serial = serial;
		scl_rise = r_reg.filt[PIN_CLK] & ~r_reg.prev[PIN_CLK];
		scl_fall = ~r_reg.filt[PIN_CLK] & r_reg.prev[PIN_CLK];
		start_seen = r_reg.filt[PIN_CLK] & r_reg.prev[PIN_CLK]
			& r_reg.prev[PIN_DATA] & ~r_reg.filt[PIN_DATA];
		stop_seen = r_reg.filt[PIN_CLK] & r_reg.prev[PIN_CLK]
			& ~r_reg.prev[PIN_DATA] & r_reg.filt[PIN_DATA];

		if (r_reg.busy) begin
			if (r_reg.busy_cnt == 16'h0000)
				r_next.busy = 1'b0;
			else
				r_next.busy_cnt = r_reg.busy_cnt - 16'h0001;
		end

		if (!serial) begin
			r_next.st = ST_IDLE;
			r_next.sda_oe = 1'b0;
		end else if (start_seen) begin
			r_next.st = ST_RX;
			r_next.what = W_ADDR;
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (stop_seen) begin
			r_next.st = ST_IDLE;
			r_next.sda_oe = 1'b0;
		end else begin
			unique case (r_reg.st)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (scl_rise) begin
						r_next.shreg = {r_reg.shreg[6:0], r_reg.filt[PIN_DATA]};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
						r_next.bitcnt = 4'h0;
						r_next.st = ST_ACK;
						r_next.sda_oe = 1'b1;
						unique case (r_reg.what)
							W_ADDR: begin
								if (r_reg.shreg[7:1] == {ADDR_UPPER, r_reg.vol[OFF_ADDR][1:0]}) begin
									r_next.rw = r_reg.shreg[0];
									r_next.what = W_CMD;
									r_next.rd_left = r_reg.single ? 8'h01 : r_reg.vol[OFF_BYTE_COUNT];
								end else begin
									r_next.st = ST_IDLE;
									r_next.sda_oe = 1'b0;
								end
							end
							W_CMD: begin
								r_next.single = r_reg.shreg[7];
								r_next.ptr = r_reg.shreg[6:0];
								r_next.what = W_DATA;
							end
							default: begin
								if (r_reg.busy) begin
									r_next.st = ST_IDLE;
									r_next.sda_oe = 1'b0;
								end else begin
									wb = r_reg.shreg;
									if (r_reg.ptr != OFF_ID && int'(r_reg.ptr) < CFG_BYTES) begin
										if (r_reg.ptr == OFF_ADDR) begin
											wb[BIT_NVM_GO] = 1'b0;
											wb[BIT_BUSY] = 1'b0;
										end
										r_next.vol[r_reg.ptr] = wb;
									end
									if (r_reg.ptr == OFF_ADDR && r_reg.shreg[BIT_NVM_GO]) begin
										r_next.nvm = r_next.vol;
										r_next.busy = 1'b1;
										r_next.busy_cnt = 16'(NVM_WRITE_CYCLES - 1);
									end
									if (!r_reg.single)
										r_next.ptr = r_reg.ptr + 7'h01;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.st = ST_RX;
						if (r_reg.rw) begin
							r_next.shreg = rd_byte(r_reg, r_reg.ptr);
							r_next.sda_oe = ~r_next.shreg[7];
							r_next.st = ST_TX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (r_reg.bitcnt == 4'h7) begin
							r_next.sda_oe = 1'b0;
							r_next.st = ST_MACK;
							r_next.bitcnt = 4'h0;
						end else begin
							r_next.shreg = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shreg[6];
							r_next.bitcnt = r_reg.bitcnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise)
						r_next.mack = ~r_reg.filt[PIN_DATA];
					else if (scl_fall) begin
						r_next.st = ST_IDLE;
						if (r_reg.mack && r_reg.rd_left > 8'h01) begin
							r_next.ptr = r_reg.ptr + 7'h01;
							r_next.rd_left = r_reg.rd_left - 8'h01;
							r_next.shreg = rd_byte(r_reg, r_next.ptr);
							r_next.sda_oe = ~r_next.shreg[7];
							r_next.st = ST_TX;
						end
					end
				end
				default: begin
					r_next.st = ST_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end

		// Serial mode forces the upper two index bits low
		r_next.sel = serial ? {2'b00, r_reg.filt[PIN_CTL]}
			: {r_reg.filt[PIN_CLK], r_reg.filt[PIN_DATA], r_reg.filt[PIN_CTL]};
		r_next.single_st = r_reg.vol[OFF_Y1_SEL][r_reg.sel]
			? r_reg.vol[OFF_Y1_STATE][3:2] : r_reg.vol[OFF_Y1_STATE][1:0];
		for (int g = 0; g < PLL_COUNT; g++) begin
			base = PLL_BASE + g * PLL_STRIDE;
			r_next.fs[g] = r_reg.vol[base + PLL_FS_OFF][r_reg.sel];
			r_next.pair[g] = r_reg.vol[base + PLL_PAIR_OFF][r_reg.sel]
				? r_reg.vol[base + PLL_STATE_OFF][3:2] : r_reg.vol[base + PLL_STATE_OFF][1:0];
			ssc_bits = {r_reg.vol[base + PLL_SSC_OFF + 2], r_reg.vol[base + PLL_SSC_OFF + 1],
				r_reg.vol[base + PLL_SSC_OFF]} >> (SSC_BITS * int'(r_reg.sel));
			r_next.steps[g] = (ssc_bits[2:0] == SSC_CODE_MAX) ? SSC_MAX_STEPS
				: {1'b0, ssc_bits[2:0]};
			r_next.down[g] = (ssc_bits[2:0] == SSC_CODE_MAX)
				| r_reg.vol[base + PLL_STATE_OFF][BIT_SPREAD_DOWN];
		end

		if (!aresetn) begin
			r_next = '0;
			for (int i = 0; i < CFG_BYTES; i++)
				r_next.nvm[i] = nvm_factory_load ? ccsc_factory_byte(i) : r_reg.nvm[i];
			r_next.vol = r_next.nvm;
			r_next.st = ST_IDLE;
			r_next.what = W_ADDR;
			r_next.sync1 = 4'h7;
			r_next.sync2 = 4'h7;
			r_next.sync3 = 4'h7;
			r_next.filt = 4'h7;
			r_next.prev = 4'h7;
			r_next.serial = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		r_reg <= r_next;
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = r_reg.sda_oe;
	assign pll_freq_select = r_reg.fs;
	assign spread_steps = r_reg.steps;
	assign spread_down = r_reg.down;
	assign pair_output_state = r_reg.pair;
	assign single_output_state = r_reg.single_st;
	assign setting_index = r_reg.sel;
	assign nvm_write_busy = r_reg.busy;
	assign serial_enabled = r_reg.serial;
endmodule : ccsc_device

// file: verilog/ccsc_host.sv
`timescale 1ns/1ps
module ccsc_host (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial lines
	ccsc_if.host bus
);
	import ccsc_pkg::*;

	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BIT = 2'h2,
		M_STOP = 2'h3
	} ccsc_mst_t;

	typedef enum logic [2:0] {
		SQ_ADDRW = 3'h0,
		SQ_CMD = 3'h1,
		SQ_WDATA = 3'h2,
		SQ_ADDRR = 3'h3,
		SQ_RDATA = 3'h4
	} ccsc_seq_t;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [4:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] cmd;
		logic [31:0] txdata;
		logic [31:0] rxdata;
		logic [2:0] len;
		logic busy;
		logic nack;
		logic s1;
		logic s2;
		logic s3;
		logic sda;
		logic [7:0] qcnt;
		logic [1:0] q;
		ccsc_mst_t mst;
		ccsc_seq_t seq;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic ackbit;
		logic [2:0] nbytes;
		logic scl_oe;
		logic sda_oe;
	} ccsc_host_t;

	ccsc_host_t r_reg;
	ccsc_host_t r_next;

	logic tick;
	logic last;
	logic [2:0] nb1;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = bus.sda;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3)
			r_next.sda = r_reg.s3;
		tick = (r_reg.qcnt == 8'h00);
		r_next.qcnt = tick ? 8'(SCL_QUARTER - 1) : r_reg.qcnt - 8'h01;
		nb1 = r_reg.nbytes + 3'h1;
		last = (nb1 == r_reg.len);

		// Write channel
		if (s_axi_awvalid && !r_reg.aw_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r_reg.w_got && !r_reg.bvalid) begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata;
		end
		if (r_reg.aw_got && r_reg.w_got) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = RESP_OKAY;
			unique case (r_reg.awaddr)
				AXI_CMD: begin
					if (!r_reg.busy && s_axi_wstrb != 4'h0) begin
						r_next.cmd = r_reg.wdata;
						r_next.len = (r_reg.wdata[CMD_LEN_LSB +: 3] == 3'h0) ? 3'h1
							: r_reg.wdata[CMD_LEN_LSB +: 3];
						if (r_reg.wdata[CMD_GO]) begin
							r_next.busy = 1'b1;
							r_next.nack = 1'b0;
							r_next.rxdata = 32'h00000000;
							r_next.mst = M_START;
							r_next.q = 2'h0;
							r_next.seq = SQ_ADDRW;
							r_next.shreg = {ADDR_UPPER, r_reg.wdata[CMD_ADDR_LSB +: 2], 1'b0};
						end
					end
				end
				AXI_WDATA: begin
					if (!r_reg.busy)
						r_next.txdata = r_reg.wdata;
				end
				AXI_STATUS, AXI_RDATA: begin
				end
				default: r_next.bresp = RESP_SLVERR;
			endcase
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;

		// Read channel
		if (s_axi_arvalid && !r_reg.rvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				AXI_CMD: r_next.rdata = r_reg.cmd;
				AXI_WDATA: r_next.rdata = r_reg.txdata;
				AXI_STATUS: r_next.rdata = {30'h00000000, r_reg.nack, r_reg.busy};
				AXI_RDATA: r_next.rdata = r_reg.rxdata;
				default: begin
					r_next.rdata = 32'h00000000;
					r_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;

		// Serial master, four quarters per bit
		if (tick && r_reg.mst != M_IDLE) begin
			r_next.q = r_reg.q + 2'h1;
			unique case (r_reg.mst)
				M_START: begin
					unique case (r_reg.q)
						2'h0: r_next.sda_oe = 1'b0;
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: r_next.sda_oe = 1'b1;
						2'h3: begin
							r_next.scl_oe = 1'b1;
							r_next.mst = M_BIT;
							r_next.bitcnt = 4'h0;
						end
					endcase
				end
				M_BIT: begin
					unique case (r_reg.q)
						2'h0: begin
							if (r_reg.bitcnt != 4'h8)
								r_next.sda_oe = (r_reg.seq != SQ_RDATA) & ~r_reg.shreg[7];
							else
								r_next.sda_oe = (r_reg.seq == SQ_RDATA) & ~last;
						end
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: begin
							if (r_reg.bitcnt == 4'h8)
								r_next.ackbit = r_reg.sda;
							else if (r_reg.seq == SQ_RDATA)
								r_next.shreg = {r_reg.shreg[6:0], r_reg.sda};
						end
						2'h3: begin
							r_next.scl_oe = 1'b1;
							r_next.bitcnt = r_reg.bitcnt + 4'h1;
							if (r_reg.bitcnt != 4'h8 && r_reg.seq != SQ_RDATA)
								r_next.shreg = {r_reg.shreg[6:0], 1'b0};
							if (r_reg.bitcnt == 4'h8) begin
								r_next.bitcnt = 4'h0;
								if (r_reg.ackbit && r_reg.seq != SQ_RDATA) begin
									r_next.nack = 1'b1;
									r_next.mst = M_STOP;
								end else begin
									unique case (r_reg.seq)
										SQ_ADDRW: begin
											r_next.seq = SQ_CMD;
											r_next.shreg = r_reg.cmd[7:0];
										end
										SQ_CMD: begin
											r_next.nbytes = 3'h0;
											if (r_reg.cmd[CMD_READ]) begin
												r_next.seq = SQ_ADDRR;
												r_next.mst = M_START;
												r_next.shreg = {ADDR_UPPER, r_reg.cmd[CMD_ADDR_LSB +: 2], 1'b1};
											end else begin
												r_next.seq = SQ_WDATA;
												r_next.shreg = r_reg.txdata[7:0];
											end
										end
										SQ_WDATA: begin
											r_next.nbytes = nb1;
											r_next.shreg = 8'(r_reg.txdata >> (8 * int'(nb1)));
											if (last)
												r_next.mst = M_STOP;
										end
										SQ_ADDRR: r_next.seq = SQ_RDATA;
										default: begin
											r_next.rxdata[8 * int'(r_reg.nbytes) +: 8] = r_reg.shreg;
											r_next.nbytes = nb1;
											if (last)
												r_next.mst = M_STOP;
										end
									endcase
								end
							end
						end
					endcase
				end
				default: begin
					unique case (r_reg.q)
						2'h0: r_next.sda_oe = 1'b1;
						2'h1: r_next.scl_oe = 1'b0;
						2'h2: r_next.sda_oe = 1'b0;
						2'h3: begin
							r_next.mst = M_IDLE;
							r_next.busy = 1'b0;
						end
					endcase
				end
			endcase
		end

		if (!aresetn) begin
			r_next = '0;
			r_next.s1 = 1'b1;
			r_next.s2 = 1'b1;
			r_next.s3 = 1'b1;
			r_next.sda = 1'b1;
			r_next.mst = M_IDLE;
			r_next.seq = SQ_ADDRW;
			r_next.len = 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		r_reg <= r_next;
	end

	assign s_axi_awready = ~r_reg.aw_got & ~r_reg.bvalid;
	assign s_axi_wready = ~r_reg.w_got & ~r_reg.bvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = ~r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe = r_reg.scl_oe;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = r_reg.sda_oe;
endmodule : ccsc_host

// file: testbench/ccsc_sva.sv
`timescale 1ns/1ps
module ccsc_sva import ccsc_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Lines
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	// Length of the current low and high clock phase
	always_ff @(posedge aclk) begin
		lo_reg <= (!aresetn || scl) ? 16'h0000 : lo_reg + 16'h0001;
		hi_reg <= (!aresetn || !scl) ? 16'h0000 : hi_reg + 16'h0001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence dev_grab;
		$rose(dev_sda_oe) && !scl;
	endsequence
	sequence dev_held_high;
		##[1:300] (scl && dev_sda_oe);
	endsequence
	a_scl_low_min: assert property ($rose(scl) |-> lo_reg >= 16'(SCL_QUARTER))
		else $error("clock low phase too short");
	a_scl_high_min: assert property ($fell(scl) |-> hi_reg >= 16'(SCL_QUARTER))
		else $error("clock high phase too short");
	a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed data while clock high");
	a_ack_held: assert property (dev_grab |-> dev_held_high)
		else $error("device bit not held into clock high");
	a_sda_stable_high: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
		else $error("data moved during clock high");
	a_start_then_low: assert property (scl && $fell(sda) |-> ##[1:300] !scl)
		else $error("start not followed by clock low");
	a_no_fight: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
		else $error("both ends drive data");
	a_stop_dev_free: assert property (scl && $rose(sda) |-> !dev_sda_oe)
		else $error("device still drives at stop");
endmodule : ccsc_sva

// file: testbench/test_clock_config_serial_control.sv
`timescale 1ns/1ps
module test_clock_config_serial_control;
	import ccsc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic pin = 1'b0;
	logic nvm_load = 1'b1;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, busy, ser_en;
	logic [1:0] bresp, rresp, ystate, resp;
	logic [31:0] rdata;
	logic [PLL_COUNT-1:0] fsel, sdown;
	logic [PLL_COUNT-1:0][3:0] ssteps;
	logic [PLL_COUNT-1:0][1:0] pstate;
	logic [2:0] sidx;
	logic [31:0] exp_q[$], msk_q[$];
	int miscompares = 0, n_compared = 0;
	logic [15:0] lfsr = 16'h4173;
	ccsc_if bus_if();
	ccsc_device u_ccsc_device(.aclk(aclk), .aresetn(aresetn), .nvm_factory_load(nvm_load),
		.bus(bus_if.device), .control_pin_first(pin), .output_supply_grounded(1'b0),
		.pll_freq_select(fsel), .spread_steps(ssteps), .spread_down(sdown),
		.pair_output_state(pstate), .single_output_state(ystate), .setting_index(sidx),
		.nvm_write_busy(busy), .serial_enabled(ser_en));
	ccsc_host u_ccsc_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus(bus_if.host));
	ccsc_sva u_ccsc_sva(.aclk(aclk), .aresetn(aresetn), .scl(bus_if.scl), .sda(bus_if.sda),
		.host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe));
	initial begin
		bus_if.ext_scl_low = 1'b0;
		bus_if.ext_sda_low = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("Compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [4:0] a, input bit want, input logic [31:0] m,
		input logic [31:0] e, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		// Note only once the address is taken, so an earlier read cannot pop it
		if (want) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic ser(input logic [7:0] cmd, input logic [1:0] lo, input logic rd,
		input logic [2:0] len, input logic [31:0] d);
		logic [31:0] c, s;
		int n;
		c = {1'b1, 12'h000, len, 3'h0, rd, 2'h0, lo, cmd};
		axi_wr(AXI_WDATA, d);
		axi_wr(AXI_CMD, c);
		n = 0;
		do begin
			axi_rd(AXI_STATUS, 1'b0, 32'h0, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 40000);
		if (s[0] !== 1'b0)
			miscompares++;
	endtask : ser
	// Result watcher
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
			chk(rdata & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	initial begin
		repeat (98000) @(posedge aclk);
		miscompares++;
		stop_test();
	end
	initial begin
		logic [31:0] d;
		int code1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(ystate, OST_HIZ);
		for (int p = 0; p < PLL_COUNT; p++) begin
			chk({pstate[p], fsel[p], ssteps[p]}, {OST_HIZ, 1'b0, 4'h0});
		end
		pin <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({sidx, ystate, pstate[0], pstate[3]}, {3'h1, OST_ACTIVE, OST_ACTIVE, OST_ACTIVE});
		chk(ser_en, 1'b1);
		axi_rd(5'h14, 1'b1, 32'hffffffff, 32'h0, d);
		chk(resp, RESP_SLVERR);
		$display("Test defaults done");
		lfsr = lfsr_next(lfsr);
		code1 = 1 + lfsr % 6;
		ser(8'h10, 2'h0, 1'b0, 3'h3, {8'h00, lfsr, lfsr[1:0], 3'(code1), 3'h7});
		axi_rd(AXI_STATUS, 1'b1, 32'h2, 32'h0, d);
		repeat (2) @(posedge aclk);
		chk({sdown[0], ssteps[0]}, {1'b0, 4'(code1)});
		pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk({sdown[0], ssteps[0]}, {1'b1, SSC_MAX_STEPS});
		$display("Test spread done");
		ser(8'h86, 2'h0, 1'b1, 3'h1, 32'h0);
		axi_rd(AXI_STATUS, 1'b1, 32'h2, 32'h0, d);
		axi_rd(AXI_RDATA, 1'b1, 32'hff, 32'(CFG_BYTES), d);
		$display("Test byte read done");
		ser(8'h81, 2'h0, 1'b0, 3'h1, 32'h81);
		chk(busy, 1'b1);
		repeat (NVM_WRITE_CYCLES) @(posedge aclk);
		chk(busy, 1'b0);
		$display("Test commit done");
		// Second reset keeps the stored image: committed spread and address return
		nvm_load <= 1'b0;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({sdown[0], ssteps[0]}, {1'b1, SSC_MAX_STEPS});
		ser(8'h81, 2'h0, 1'b1, 3'h1, 32'h0);
		axi_rd(AXI_STATUS, 1'b1, 32'h2, 32'h2, d);
		ser(8'h81, 2'h1, 1'b1, 3'h1, 32'h0);
		axi_rd(AXI_STATUS, 1'b1, 32'h2, 32'h0, d);
		axi_rd(AXI_RDATA, 1'b1, 32'hff, 32'h01, d);
		$display("Test address done");
		stop_test();
	end
endmodule : test_clock_config_serial_control
